/* File: tb/rfrs_link_monitor.sv */
`timescale 1ns/1ps
// watches the two-bus link between controller and device
module rfrs_link_monitor #(
    parameter int unsigned TICK_CYC = 4,
    parameter int unsigned ADR_MS   = 5
) (
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic [2:0] cmd0,
    input wire logic       cmdStb0,
    input wire logic [2:0] cmd1,
    input wire logic       cmdStb1,
    input wire logic       alert0N,
    input wire logic       alert1N,
    input wire logic [7:0] status,
    input wire logic       ctrlBus,
    input wire logic [6:0] busAddr
);
    localparam int ADR_CYC = TICK_CYC * ADR_MS - 2;
    logic [15:0] sinceRst_r;
    logic        tko0, tko1, clr0, clr1;
    // decoded command strobes
    assign tko0 = cmdStb0 && cmd0 == rfrs_pkg::CMD_TAKEOVER;
    assign tko1 = cmdStb1 && cmd1 == rfrs_pkg::CMD_TAKEOVER;
    assign clr0 = cmdStb0 && cmd0 == rfrs_pkg::CMD_CLEAR;
    assign clr1 = cmdStb1 && cmd1 == rfrs_pkg::CMD_CLEAR;
    // cycles since reset release, saturating
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) sinceRst_r <= 16'h0000;
        else if (sinceRst_r != 16'hffff) sinceRst_r <= sinceRst_r + 16'h0001;
    end
    takeover_bus1_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        tko1 && !ctrlBus |=> ctrlBus && !alert0N && !alert1N) else $error("bus1 takeover");
    takeover_bus0_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        tko0 && ctrlBus |=> !ctrlBus && !alert0N && !alert1N) else $error("bus0 takeover");
    alert0_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !alert0N && !clr0 |=> !alert0N) else $error("alert0 dropped");
    alert1_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !alert1N && !clr1 |=> !alert1N) else $error("alert1 dropped");
    ctrl_by_takeover_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $changed(ctrlBus) |-> $past(tko0 || tko1)) else $error("control moved");
    addr_default_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        sinceRst_r < ADR_CYC |-> busAddr == rfrs_pkg::DEF_ADDR) else $error("early address");
    nonctrl_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clr0 && ctrlBus && !cmdStb1 |=> (status & $past(status)) == $past(status))
        else $error("status cleared by bus0");
    new_bits_alert_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (status & ~$past(status)) != 8'h00 |-> (ctrlBus ? !alert1N : !alert0N))
        else $error("no alert on change");
endmodule : rfrs_link_monitor

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int TK = 4;
    localparam int RM = 3;
    localparam int OM = 4;
    localparam int AM = 5;
    logic       sys_clk, nrst, wr, rd, enablePin, ovFault, otFault, ocFault;
    logic       limitAct, voutAbove36, vinBad, vinPresent, nvmLatchAll;
    logic       outOn, outLed, inLed, faultLed, s0, s1;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic [2:0] latchCfg;
    logic [6:0] strapAddr;
    int         n_mismatch = 0, checks = 0, cyc = 0;
    rfrs_link_if link ();
    rfrs_host rfrs_host_i (.sys_clk(sys_clk), .nrst(nrst), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    rfrs_dev #(.TICK_CYC(TK), .RST_MS(RM), .WIN_MS(50), .CC_MS(10), .OFF_MS(OM),
        .ADR_MS(AM), .BLK_MS(3)) rfrs_dev_i (.sys_clk(sys_clk), .nrst(nrst), .link(link),
        .enablePin(enablePin), .ovFault(ovFault), .otFault(otFault), .ocFault(ocFault),
        .limitAct(limitAct), .voutAbove36(voutAbove36), .vinBad(vinBad),
        .vinPresent(vinPresent), .latchCfg(latchCfg), .nvmLatchAll(nvmLatchAll),
        .strapAddr(strapAddr), .outOn(outOn), .outLed(outLed), .inLed(inLed),
        .faultLed(faultLed));
    rfrs_link_monitor #(.TICK_CYC(TK), .ADR_MS(AM)) rfrs_link_monitor_i (
        .sys_clk(sys_clk), .nrst(nrst), .cmd0(link.cmd0), .cmdStb0(link.cmdStb0),
        .cmd1(link.cmd1), .cmdStb1(link.cmdStb1), .alert0N(link.alert0N),
        .alert1N(link.alert1N), .status(link.status), .ctrlBus(link.ctrlBus),
        .busAddr(link.busAddr));
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t value %h expected %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t pin %b expected %b", $time, g, e);
        end
    endtask : chk1
    // register port cycles
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk) wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk) wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a);
        @(posedge sys_clk) rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk) rd <= 1'b0;
        @(negedge sys_clk) rv = rdata;
    endtask : rreg
    task automatic cmd(input logic b, input logic [2:0] c);
        wreg(rfrs_pkg::REG_CMD, {4'h0, b, c});
        repeat (4) @(posedge sys_clk);
    endtask : cmd
    task automatic wait_out(input logic v, input int n);
        int k;
        k = 0;
        while (outOn !== v && k < n) begin
            @(negedge sys_clk);
            k++;
        end
        chk1(outOn, v);
    endtask : wait_out
    task automatic t_reset;
        rreg(rfrs_pkg::REG_STATUS);
        chk8(rv, 8'h80);
        rreg(rfrs_pkg::REG_ALERT);
        chk8(rv, 8'h00);
        rreg(4'hf);
        chk8(rv, 8'h00);
        chk8({1'b0, link.busAddr}, {1'b0, rfrs_pkg::DEF_ADDR});
        // no addressed command until the address settles
        repeat (AM * TK + 4) @(negedge sys_clk);
        chk8({1'b0, link.busAddr}, {1'b0, strapAddr});
        $display("t_reset done");
    endtask : t_reset
    task automatic t_clear;
        cmd(1'b0, rfrs_pkg::CMD_CLEAR);
        rreg(rfrs_pkg::REG_ALERT);
        chk8(rv, 8'h01);
        rreg(rfrs_pkg::REG_STATUS);
        chk8(rv, 8'h00);
        cmd(1'b1, rfrs_pkg::CMD_CLEAR);
        rreg(rfrs_pkg::REG_ALERT);
        chk8(rv, 8'h03);
        $display("t_clear done");
    endtask : t_clear
    task automatic t_xfer;
        cmd(1'b1, rfrs_pkg::CMD_TAKEOVER);
        rreg(rfrs_pkg::REG_ALERT);
        chk8(rv, 8'h04);
        cmd(1'b0, rfrs_pkg::CMD_CLEAR);
        rreg(rfrs_pkg::REG_ALERT);
        chk8(rv, 8'h05);
        cmd(1'b1, rfrs_pkg::CMD_CLEAR);
        rreg(rfrs_pkg::REG_ALERT);
        chk8(rv, 8'h07);
        $display("t_xfer done");
    endtask : t_xfer
    task automatic t_noctrl;
        cmd(1'b0, rfrs_pkg::CMD_OUT_OFF);
        repeat (8) @(negedge sys_clk);
        chk1(outOn, 1'b1);
        cmd(1'b1, rfrs_pkg::CMD_OUT_OFF);
        wait_out(1'b0, 20);
        chk1(outLed, 1'b0);
        cmd(1'b1, rfrs_pkg::CMD_OUT_ON);
        wait_out(1'b1, 60);
        chk1(outLed, 1'b1);
        $display("t_noctrl done");
    endtask : t_noctrl
    task automatic t_fault;
        @(posedge sys_clk) otFault <= 1'b1;
        wait_out(1'b0, 20);
        chk1(faultLed, 1'b1);
        cmd(1'b0, rfrs_pkg::CMD_CLEAR);
        rreg(rfrs_pkg::REG_STATUS);
        chk1(rv[rfrs_pkg::ST_OT], 1'b1);
        @(posedge sys_clk) otFault <= 1'b0;
        wait_out(1'b1, RM * TK + 40);
        rreg(rfrs_pkg::REG_STATUS);
        chk1(rv[rfrs_pkg::ST_RESTARTED], 1'b1);
        cmd(1'b1, rfrs_pkg::CMD_CLEAR);
        $display("t_fault done");
    endtask : t_fault
    task automatic t_limit;
        s0 = 1'b0;
        s1 = 1'b0;
        @(posedge sys_clk) limitAct <= 1'b1;
        repeat (8 * 3 * TK) begin
            @(negedge sys_clk);
            s0 = s0 | !outLed;
            s1 = s1 | outLed;
        end
        chk1(s0 & s1, 1'b1);
        chk1(faultLed, 1'b0);
        @(posedge sys_clk) voutAbove36 <= 1'b0;
        wait_out(1'b0, 40);
        @(posedge sys_clk) limitAct <= 1'b0;
        voutAbove36 <= 1'b1;
        wait_out(1'b1, RM * TK + 40);
        $display("t_limit done");
    endtask : t_limit
    task automatic t_input;
        s0 = 1'b0;
        s1 = 1'b0;
        @(posedge sys_clk) vinBad <= 1'b1;
        repeat (8 * 3 * TK) begin
            @(negedge sys_clk);
            s0 = s0 | !inLed;
            s1 = s1 | inLed;
        end
        chk1(s0 & s1, 1'b1);
        chk1(faultLed, 1'b0);
        @(posedge sys_clk) vinPresent <= 1'b0;
        repeat (8) @(negedge sys_clk);
        chk1(inLed, 1'b0);
        @(posedge sys_clk) vinBad <= 1'b0;
        vinPresent <= 1'b1;
        repeat (8) @(negedge sys_clk);
        chk1(inLed, 1'b1);
        $display("t_input done");
    endtask : t_input
    task automatic t_latch;
        @(posedge sys_clk) latchCfg <= 3'h2;
        otFault <= 1'b1;
        wait_out(1'b0, 20);
        @(posedge sys_clk) otFault <= 1'b0;
        repeat (RM * TK + 20) @(negedge sys_clk);
        chk1(outOn, 1'b0);
        chk1(outLed, 1'b0);
        rreg(rfrs_pkg::REG_STATUS);
        chk1(rv[rfrs_pkg::ST_LATCHED], 1'b1);
        @(posedge sys_clk) enablePin <= 1'b0;
        repeat (OM * TK + 8) @(posedge sys_clk);
        enablePin <= 1'b1;
        wait_out(1'b1, 60);
        @(posedge sys_clk) latchCfg <= 3'h0;
        $display("t_latch done");
    endtask : t_latch
    task automatic t_ov;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk) ovFault <= 1'b1;
            wait_out(1'b0, 20);
            @(posedge sys_clk) ovFault <= 1'b0;
            if (i < 2) begin
                repeat (RM * TK - 5) @(negedge sys_clk);
                chk1(outOn, 1'b0);
                wait_out(1'b1, 20);
            end
        end
        repeat (RM * TK + 20) @(negedge sys_clk);
        chk1(outOn, 1'b0);
        $display("t_ov done");
    endtask : t_ov
    // reset, then scenarios in order
    initial begin
        {nrst, wr, rd, ovFault, otFault, ocFault, limitAct, vinBad, nvmLatchAll} = 9'h000;
        {enablePin, voutAbove36, vinPresent} = 3'h7;
        addr = 4'h0;
        wdata = 8'h00;
        latchCfg = 3'h0;
        strapAddr = 7'h25;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_clear();
        t_xfer();
        t_noctrl();
        t_fault();
        t_limit();
        t_input();
        t_latch();
        t_ov();
        stop_test();
    end
endmodule : testbench

/* File: verilog/rfrs_dev.sv */
`timescale 1ns/1ps
// Operation
// - control transfer alerts both buses
// - each master clears own alert
// - fault clear only from controlling master
// - non-controller: only takeover and clear
// - auto restart default, nvm changeable
// - startup current limit held 20 s
// - limit above 36 V blinks output LED
// - limit below 36 V restart: hiccup
// - output LED follows on/off state
// - OV/OT/OC each configurable latch-off
// - latch restart needs cycle, 2 s off
// - restart clears alarms, sets restarted flag
// - OC and OT default auto restart
// - OV: two retries 1 s apart, latch on third
// - window ends: reset OV count
// - freeze status at final state, alert
// - frozen status accumulates new changes
// - external faults raise no fault indication
// - input LED blinks out of range
// - power-up raises state change
// - status pattern change asserts alert
// - default address until address settles
// - host waits 1 s after insertion
module rfrs_dev #(
    parameter int unsigned TICK_CYC = rfrs_pkg::TICK_CYC,
    parameter int unsigned RST_MS   = rfrs_pkg::RESTART_MS,
    parameter int unsigned WIN_MS   = rfrs_pkg::WINDOW_MS,
    parameter int unsigned CC_MS    = rfrs_pkg::CC_HOLD_MS,
    parameter int unsigned OFF_MS   = rfrs_pkg::OFF_MIN_MS,
    parameter int unsigned ADR_MS   = rfrs_pkg::ADDR_SETTLE_MS,
    parameter int unsigned BLK_MS   = rfrs_pkg::BLINK_MS
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    rfrs_link_if.dev        link,
    input  wire logic       enablePin,
    input  wire logic       ovFault,
    input  wire logic       otFault,
    input  wire logic       ocFault,
    input  wire logic       limitAct,
    input  wire logic       voutAbove36,
    input  wire logic       vinBad,
    input  wire logic       vinPresent,
    input  wire logic [2:0] latchCfg,
    input  wire logic       nvmLatchAll,
    input  wire logic [6:0] strapAddr,
    output logic            outOn,
    output logic            outLed,
    output logic            inLed,
    output logic            faultLed
);
    typedef enum logic [1:0] {RUN, WAIT_RETRY, LATCHED} rfrs_pwr_type;

    typedef struct packed {
        logic [7:0]   s1;        // pin synchronisers stage 1
        logic [7:0]   s2;
        logic [17:0]  pre;
        logic         tick;
        logic [15:0]  tmr;       // restart / off timer
        logic [15:0]  win;       // ov window timer
        logic [15:0]  ccT;       // startup current-limit timer
        logic [15:0]  adrT;
        logic [15:0]  blkT;
        logic         blink;
        logic [1:0]   ovCnt;
        rfrs_pwr_type pwr;
        logic         outOn;
        logic         wantOn;    // command output state
        logic [7:0]   live;
        logic [7:0]   held;
        logic         ctrl;      // bus in control
        logic         a0;
        logic         a1;
        logic         frozen;
        logic [6:0]   addr;
        logic         outLed;
        logic         inLed;
        logic         faultLed;
        logic         lastEn;
        logic         lastCmd;
        logic [2:0]   latchWhy;  // faults behind the latch: oc, ot, ov
    } rfrs_dev_type;
    rfrs_dev_type st_r, st_nxt;

    logic [7:0] pins;
    assign pins = {enablePin, ovFault, otFault, ocFault, limitAct, voutAbove36, vinBad,
                   vinPresent};

    always_comb begin
        logic       ov, ot, oc, lim, hi, vb, vp, en, ext, restartReq, faultNow;
        logic [7:0] nlive;
        logic [2:0] cfgMask;
        cfgMask = latchCfg | {3{nvmLatchAll}};
        st_nxt = st_r;
        {en, ov, ot, oc, lim, hi, vb, vp} = st_r.s2;
        nlive      = 8'h00;
        restartReq = 1'b0;
        faultNow   = 1'b0;
        ext        = 1'b0;
        st_nxt.s1  = pins;
        st_nxt.s2  = st_r.s1;
        // millisecond prescaler
        st_nxt.tick = 1'b0;
        if (st_r.pre == 18'(TICK_CYC - 1)) begin
            st_nxt.pre  = 18'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.pre = st_r.pre + 18'h1;
        end
        if (st_r.tick) begin
            if (st_r.tmr != 16'h0) st_nxt.tmr = st_r.tmr - 16'h1;
            if (st_r.win != 16'h0) st_nxt.win = st_r.win - 16'h1;
            if (st_r.ccT != 16'h0) st_nxt.ccT = st_r.ccT - 16'h1;
            if (st_r.adrT != 16'h0) st_nxt.adrT = st_r.adrT - 16'h1;
            if (st_r.blkT == 16'h0) begin
                st_nxt.blkT  = 16'(BLK_MS - 1);
                st_nxt.blink = ~st_r.blink;
            end else begin
                st_nxt.blkT = st_r.blkT - 16'h1;
            end
        end
        // address settles after insertion
        if (st_r.adrT == 16'h0) st_nxt.addr = strapAddr;
        // ov window expiry resets retry count
        // a count that has latched stays until a restart request
        if (st_r.win == 16'h0 && st_r.pwr != LATCHED) st_nxt.ovCnt = 2'h0;
        // output on/off request by command from controlling bus
        if (link.cmdStb0 && !st_r.ctrl && link.cmd0 == rfrs_pkg::CMD_OUT_OFF)
            st_nxt.wantOn = 1'b0;
        if (link.cmdStb0 && !st_r.ctrl && link.cmd0 == rfrs_pkg::CMD_OUT_ON)
            st_nxt.wantOn = 1'b1;
        if (link.cmdStb1 && st_r.ctrl && link.cmd1 == rfrs_pkg::CMD_OUT_OFF)
            st_nxt.wantOn = 1'b0;
        if (link.cmdStb1 && st_r.ctrl && link.cmd1 == rfrs_pkg::CMD_OUT_ON)
            st_nxt.wantOn = 1'b1;
        restartReq = (en && st_r.lastEn == 1'b0) || (st_nxt.wantOn && !st_r.lastCmd);
        st_nxt.lastEn  = en;
        st_nxt.lastCmd = st_nxt.wantOn;
        // overload during startup is held in current limit
        faultNow = ov || ot || (oc && st_r.ccT == 16'h0);
        ext      = lim || vb;
        case (st_r.pwr)
            RUN: begin
                st_nxt.outOn = en && st_r.wantOn;
                if (st_r.outOn && (faultNow || (lim && !hi && !nvmLatchAll))) begin
                    st_nxt.outOn = 1'b0;
                    st_nxt.tmr   = 16'(RST_MS);
                    st_nxt.pwr   = WAIT_RETRY;
                    if (ov) begin
                        if (st_r.ovCnt == 2'h0) st_nxt.win = 16'(WIN_MS);
                        st_nxt.ovCnt = st_r.ovCnt + 2'h1;
                        if (st_r.ovCnt == rfrs_pkg::OV_RETRY_MAX - 2'h1 || latchCfg[0] ||
                            nvmLatchAll)
                            st_nxt.pwr = LATCHED;
                    end
                    // oc and ot restart unless configured to latch
                    if ((ot && (latchCfg[1] || nvmLatchAll)) ||
                        (oc && (latchCfg[2] || nvmLatchAll)))
                        st_nxt.pwr = LATCHED;
                    if (st_nxt.pwr == LATCHED) begin
                        st_nxt.tmr      = 16'(OFF_MS);
                        st_nxt.latchWhy = {oc, ot, ov};
                    end
                end
            end
            WAIT_RETRY: begin
                if (st_r.tmr == 16'h0 && !faultNow) begin
                    st_nxt.pwr    = RUN;
                    st_nxt.outOn  = en && st_r.wantOn;
                    st_nxt.held   = rfrs_pkg::STAT_RESET;
                    st_nxt.held[rfrs_pkg::ST_RESTARTED] = 1'b1;
                end
            end
            LATCHED: begin
                // switching config to restart needs no minimum off time
                // release only when the latching fault's own config turns to restart
                if ((restartReq && st_r.tmr == 16'h0) ||
                    (st_r.latchWhy != 3'h0 && (st_r.latchWhy & cfgMask) == 3'h0 &&
                     st_r.ovCnt != rfrs_pkg::OV_RETRY_MAX)) begin
                    st_nxt.pwr      = WAIT_RETRY;
                    st_nxt.tmr      = 16'h0;
                    st_nxt.ovCnt    = 2'h0;
                    st_nxt.latchWhy = 3'h0;
                end
            end
            default: st_nxt.pwr = LATCHED;
        endcase
        // live status; external faults kept out of alarm bits
        nlive[rfrs_pkg::ST_OV]      = ov;
        nlive[rfrs_pkg::ST_OT]      = ot;
        nlive[rfrs_pkg::ST_OC]      = oc && st_r.ccT == 16'h0;
        nlive[rfrs_pkg::ST_LIMIT]   = lim;
        nlive[rfrs_pkg::ST_INPUT]   = vb;
        nlive[rfrs_pkg::ST_LATCHED] = st_r.pwr == LATCHED;
        st_nxt.live = nlive;
        // freeze only in final state; later changes added in
        if (st_r.pwr != WAIT_RETRY && nlive != st_r.live) begin
            st_nxt.held = st_r.held | nlive;
            if (!st_r.ctrl) st_nxt.a0 = 1'b1;
            else st_nxt.a1 = 1'b1;
            st_nxt.frozen = 1'b1;
        end
        // clears: each bus its own alert, registers only by controller
        if (link.cmdStb0 && link.cmd0 == rfrs_pkg::CMD_CLEAR) begin
            st_nxt.a0 = 1'b0;
            if (!st_r.ctrl) begin
                st_nxt.held   = st_r.live;
                st_nxt.frozen = 1'b0;
            end
        end
        if (link.cmdStb1 && link.cmd1 == rfrs_pkg::CMD_CLEAR) begin
            st_nxt.a1 = 1'b0;
            if (st_r.ctrl) begin
                st_nxt.held   = st_r.live;
                st_nxt.frozen = 1'b0;
            end
        end
        // control transfer alerts both buses, set wins over clear
        if ((link.cmdStb0 && link.cmd0 == rfrs_pkg::CMD_TAKEOVER && st_r.ctrl) ||
            (link.cmdStb1 && link.cmd1 == rfrs_pkg::CMD_TAKEOVER && !st_r.ctrl)) begin
            st_nxt.ctrl = ~st_r.ctrl;
            st_nxt.a0   = 1'b1;
            st_nxt.a1   = 1'b1;
        end
        // leds
        if (lim && hi) st_nxt.outLed = st_r.blink;
        else st_nxt.outLed = st_nxt.outOn;
        st_nxt.inLed    = vp && (vb ? st_r.blink : 1'b1);
        st_nxt.faultLed = (ov || ot || nlive[rfrs_pkg::ST_OC]) && !ext;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{pre: 18'h0, tmr: 16'h0, win: 16'h0, ccT: 16'(CC_MS),
                      adrT: 16'(ADR_MS), blkT: 16'h0, ovCnt: 2'h0, pwr: RUN,
                      held: 8'h80, a0: 1'b1, a1: 1'b1, frozen: 1'b1,
                      addr: rfrs_pkg::DEF_ADDR, wantOn: 1'b1, lastCmd: 1'b1,
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.alert0N = ~st_r.a0;
    assign link.alert1N = ~st_r.a1;
    assign link.status  = st_r.held;
    assign link.ctrlBus = st_r.ctrl;
    assign link.busAddr = st_r.addr;
    assign outOn        = st_r.outOn;
    assign outLed       = st_r.outLed;
    assign inLed        = st_r.inLed;
    assign faultLed     = st_r.faultLed;
endmodule : rfrs_dev

/* File: verilog/rfrs_host.sv */
`timescale 1ns/1ps
// two controllers driven from one register port; bit 3 of command picks bus
module rfrs_host (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    rfrs_link_if.host       link,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata
);
    typedef struct packed {
        logic [2:0] cmd0;
        logic       stb0;
        logic [2:0] cmd1;
        logic       stb1;
        logic [7:0] rdata;
        logic [1:0] aS1;
        logic [1:0] aS2;
    } rfrs_host_type;
    rfrs_host_type st_r, st_nxt;

    // command issue and read-back
    always_comb begin
        st_nxt       = st_r;
        st_nxt.stb0  = 1'b0;
        st_nxt.stb1  = 1'b0;
        st_nxt.rdata = 8'h00;
        st_nxt.aS1   = {link.alert1N, link.alert0N};
        st_nxt.aS2   = st_r.aS1;
        if (wr && addr == rfrs_pkg::REG_CMD) begin
            if (wdata[3]) begin
                st_nxt.cmd1 = wdata[2:0];
                st_nxt.stb1 = 1'b1;
            end else begin
                st_nxt.cmd0 = wdata[2:0];
                st_nxt.stb0 = 1'b1;
            end
        end
        if (rd) begin
            case (addr)
                rfrs_pkg::REG_STATUS: st_nxt.rdata = link.status;
                rfrs_pkg::REG_ALERT:  st_nxt.rdata = {5'h00, link.ctrlBus, st_r.aS2};
                default:              st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{cmd0: 3'h0, stb0: 1'b0, cmd1: 3'h0, stb1: 1'b0,
                      rdata: 8'h00, aS1: 2'h3, aS2: 2'h3};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.cmd0    = st_r.cmd0;
    assign link.cmdStb0 = st_r.stb0;
    assign link.cmd1    = st_r.cmd1;
    assign link.cmdStb1 = st_r.stb1;
    assign rdata        = st_r.rdata;
endmodule : rfrs_host

/* File: verilog/rfrs_link_if.sv */
`timescale 1ns/1ps
// two-bus command path: one command strobe per bus, alert per bus
interface rfrs_link_if;
    logic [2:0] cmd0;
    logic       cmdStb0;
    logic [2:0] cmd1;
    logic       cmdStb1;
    logic       alert0N;
    logic       alert1N;
    logic [7:0] status;
    logic       ctrlBus;
    logic [6:0] busAddr;
    modport dev  (input cmd0, cmdStb0, cmd1, cmdStb1,
                  output alert0N, alert1N, status, ctrlBus, busAddr);
    modport host (output cmd0, cmdStb0, cmd1, cmdStb1,
                  input alert0N, alert1N, status, ctrlBus, busAddr);
endinterface : rfrs_link_if

/* File: verilog/rfrs_pkg.sv */
package rfrs_pkg;
    // prescaler: one tick per 1 ms at 250 MHz
    localparam int unsigned CLK_HZ          = 250000000;
    localparam int unsigned TICK_NS         = 1000000;
    localparam int unsigned TICK_CYC        = TICK_NS / 4;
    // timing in ms
    localparam int unsigned RESTART_MS      = 1000;
    localparam int unsigned WINDOW_MS       = 60000;
    localparam int unsigned CC_HOLD_MS      = 20000;
    localparam int unsigned OFF_MIN_MS      = 2000;
    localparam int unsigned ADDR_SETTLE_MS  = 1000;
    localparam int unsigned BLINK_MS        = 500;
    localparam logic [1:0]  OV_RETRY_MAX    = 2'h3;
    localparam logic [6:0]  DEF_ADDR        = 7'h00;
    localparam logic [7:0]  STAT_RESET      = 8'h00;
    // host command codes
    localparam logic [2:0]  CMD_NONE        = 3'h0;
    localparam logic [2:0]  CMD_CLEAR       = 3'h1;
    localparam logic [2:0]  CMD_TAKEOVER    = 3'h2;
    localparam logic [2:0]  CMD_OUT_OFF     = 3'h3;
    localparam logic [2:0]  CMD_OUT_ON      = 3'h4;
    localparam logic [2:0]  CMD_READ_STAT   = 3'h5;
    // host register offsets
    localparam logic [3:0]  REG_CMD         = 4'h0;
    localparam logic [3:0]  REG_STATUS      = 4'h1;
    localparam logic [3:0]  REG_ALERT       = 4'h2;
    // status bit positions
    localparam int unsigned ST_OV           = 0;
    localparam int unsigned ST_OT           = 1;
    localparam int unsigned ST_OC           = 2;
    localparam int unsigned ST_LIMIT        = 3;
    localparam int unsigned ST_INPUT        = 4;
    localparam int unsigned ST_LATCHED      = 5;
    localparam int unsigned ST_RESTARTED    = 6;
    localparam int unsigned ST_POWERUP      = 7;
endpackage : rfrs_pkg
